// ### sdp_fifo.v
`timescale 1ns/1ps

module sdp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             CLK,
    input  wire             RESETN,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // ==========================================================
    // Status
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    // ==========================================================
    // Storage
    always @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

// ### sdp_map.vh
`ifndef SDP_MAP_VH
`define SDP_MAP_VH

// ==========================================================
// Register offsets (byte addresses, one 32-bit word each)
`define SDP_ADDR_W        8
`define SDP_REG_CTRL      8'h00
`define SDP_REG_DELIM     8'h04
`define SDP_REG_PACK_LEN  8'h08
`define SDP_REG_IDLE_MS   8'h0C
`define SDP_REG_STATUS    8'h10
`define SDP_REG_PKT_CNT   8'h14

// ==========================================================
// Field positions
`define SDP_CTRL_D1_EN    0
`define SDP_CTRL_D2_EN    1
`define SDP_CTRL_MODE_LO  4
`define SDP_CTRL_MODE_HI  5
`define SDP_STAT_SENDING  16

// ==========================================================
// Delimiter handling modes
`define SDP_MODE_PASS     2'h0
`define SDP_MODE_PLUS1    2'h1
`define SDP_MODE_PLUS2    2'h2
`define SDP_MODE_STRIP    2'h3

// ==========================================================
// Reset values
`define SDP_RST_CTRL      32'h0000_0000
`define SDP_RST_DELIM     16'h0000
`define SDP_RST_PACK_LEN  11'h000
`define SDP_RST_IDLE_MS   16'h0000

// ==========================================================
// Sizes
`define SDP_LEN_MAX       11'h400
`define SDP_BUF_DEPTH     1024
`define SDP_CNT_W         11
`define SDP_FIFO_DEPTH    16
`define SDP_FIFO_AW       4

// ==========================================================
// Timing
`define SDP_CLK_NS        25
`define SDP_MS_NS         1000000
`define SDP_MS_CYCLES     (`SDP_MS_NS / `SDP_CLK_NS)

`endif

// ### sdp_packer.v
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "sdp_map.vh"

module sdp_packer #(
    parameter MS_CYCLES = `SDP_MS_CYCLES
) (
    input  wire                   CLK,
    input  wire                   RESETN,
    input  wire [`SDP_ADDR_W-1:0] ADDR,
    input  wire [31:0]            WDATA,
    input  wire                   WE,
    input  wire                   RE,
    output reg  [31:0]            RDATA,
    input  wire [7:0]             RX_DATA,
    input  wire                   RX_VALID,
    output wire                   RX_READY,
    output reg  [7:0]             TX_DATA,
    output reg                    TX_VALID,
    output reg                    TX_LAST,
    input  wire                   TX_READY
);
    localparam ST_COLLECT = 1'b0;
    localparam ST_SEND    = 1'b1;
    localparam [31:0] MS_LAST   = MS_CYCLES - 1;
    localparam [15:0] RST_DELIM = `SDP_RST_DELIM;

    reg  [7:0]            pbuf [0:`SDP_BUF_DEPTH-1];
    reg                   state;
    reg  [`SDP_CNT_W-1:0] count;
    reg  [`SDP_CNT_W-1:0] pkt_len;
    reg  [`SDP_CNT_W-1:0] rd_idx;
    reg                   d1_seen;
    reg  [1:0]            pend;
    reg  [15:0]           prescale;
    reg  [15:0]           idle_ms;
    reg  [31:0]           pkt_cnt;
    reg                   d1_en;
    reg                   d2_en;
    reg  [1:0]            mode;
    reg  [7:0]            d1_val;
    reg  [7:0]            d2_val;
    reg  [`SDP_CNT_W-1:0] len_thr;
    reg  [15:0]           idle_thr;

    wire [7:0]            byte_in;
    wire                  byte_valid;
    wire                  byte_take;
    wire [1:0]            eff_mode;
    wire [`SDP_CNT_W-1:0] next_count;
    wire                  is_d1;
    wire                  is_d2;
    reg                   match;
    reg  [1:0]            match_len;
    reg                   pack_now;
    reg  [`SDP_CNT_W-1:0] next_pkt_len;
    reg  [1:0]            next_pend;
    wire                  timeout;
    wire                  ms_tick;
    wire                  tx_load;
    wire                  send_done;

    // ==========================================================
    // Input FIFO; while a packet drains it takes up to 16 bytes, then stalls the serial side
    sdp_fifo #(
        .WIDTH (8),
        .DEPTH (`SDP_FIFO_DEPTH),
        .AW    (`SDP_FIFO_AW)
    ) u_fifo (
        .CLK       (CLK),
        .RESETN    (RESETN),
        .in_data   (RX_DATA),
        .in_valid  (RX_VALID),
        .in_ready  (RX_READY),
        .out_data  (byte_in),
        .out_valid (byte_valid),
        .out_ready (byte_take)
    );

    assign byte_take  = (state == ST_COLLECT) && byte_valid;
    assign next_count = count + 1'b1;
    assign is_d1      = (byte_in == d1_val);
    assign is_d2      = (byte_in == d2_val);
    assign eff_mode   = (d1_en || d2_en) ? mode : `SDP_MODE_PASS;

    // ==========================================================
    // Release decision for an arriving byte
    always @* begin
        match        = 1'b0;
        match_len    = 2'h1;
        pack_now     = 1'b0;
        next_pend    = pend;
        next_pkt_len = next_count;
        if (d1_en && d2_en) begin
            match     = d1_seen && is_d2;
            match_len = 2'h2;
        end else if (d1_en) begin
            match = is_d1;
        end else if (d2_en) begin
            match = is_d2;
        end
        if (pend != 2'h0) begin
            next_pend = pend - 1'b1;
            if (pend == 2'h1) begin
                pack_now = 1'b1;
            end
        end else if (match) begin
            case (eff_mode)
                `SDP_MODE_PASS: begin
                    pack_now = 1'b1;
                end
                `SDP_MODE_PLUS1: begin
                    next_pend = 2'h1;
                end
                `SDP_MODE_PLUS2: begin
                    next_pend = 2'h2;
                end
                `SDP_MODE_STRIP: begin
                    pack_now     = 1'b1;
                    next_pkt_len = next_count - {{(`SDP_CNT_W-2){1'b0}}, match_len};
                end
                default: begin
                    pack_now = 1'b1;
                end
            endcase
        end
        if ((len_thr != {`SDP_CNT_W{1'b0}}) && (next_count >= len_thr)) begin
            pack_now = 1'b1;
        end
        if (next_count == `SDP_LEN_MAX) begin
            pack_now = 1'b1;
        end
    end

    // ==========================================================
    // Idle timer in milliseconds
    assign ms_tick = (prescale == MS_LAST[15:0]);
    assign timeout = (state == ST_COLLECT) && !byte_take && (count != {`SDP_CNT_W{1'b0}})
                     && (idle_thr != 16'h0000) && (idle_ms >= idle_thr);

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prescale <= 16'h0000;
            idle_ms  <= 16'h0000;
        end else if (byte_take || state == ST_SEND) begin
            prescale <= 16'h0000;
            idle_ms  <= 16'h0000;
        end else if (ms_tick) begin
            prescale <= 16'h0000;
            if (idle_ms != 16'hFFFF) begin
                idle_ms <= idle_ms + 16'h0001;
            end
        end else begin
            prescale <= prescale + 16'h0001;
        end
    end

    // ==========================================================
    // Port buffer write
    always @(posedge CLK) begin
        if (byte_take) begin
            pbuf[count[9:0]] <= byte_in;
        end
    end

    // ==========================================================
    // Collect and send
    assign tx_load   = (!TX_VALID || TX_READY) && (rd_idx != pkt_len);
    assign send_done = (rd_idx == pkt_len) && (!TX_VALID || TX_READY);

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state    <= ST_COLLECT;
            count    <= {`SDP_CNT_W{1'b0}};
            pkt_len  <= {`SDP_CNT_W{1'b0}};
            rd_idx   <= {`SDP_CNT_W{1'b0}};
            d1_seen  <= 1'b0;
            pend     <= 2'h0;
            pkt_cnt  <= 32'h0000_0000;
            TX_DATA  <= 8'h00;
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
        end else begin
            case (state)
                ST_COLLECT: begin
                    if (byte_take && pack_now) begin
                        count   <= {`SDP_CNT_W{1'b0}};
                        d1_seen <= 1'b0;
                        pend    <= 2'h0;
                        pkt_len <= next_pkt_len;
                        rd_idx  <= {`SDP_CNT_W{1'b0}};
                        pkt_cnt <= pkt_cnt + 32'h0000_0001;
                        if (next_pkt_len != {`SDP_CNT_W{1'b0}}) begin
                            state <= ST_SEND;
                        end
                    end else if (byte_take) begin
                        count   <= next_count;
                        d1_seen <= is_d1;
                        pend    <= next_pend;
                    end else if (timeout) begin
                        count   <= {`SDP_CNT_W{1'b0}};
                        d1_seen <= 1'b0;
                        pend    <= 2'h0;
                        pkt_len <= count;
                        rd_idx  <= {`SDP_CNT_W{1'b0}};
                        pkt_cnt <= pkt_cnt + 32'h0000_0001;
                        state   <= ST_SEND;
                    end
                    if (TX_READY) begin
                        TX_VALID <= 1'b0;
                    end
                end
                ST_SEND: begin
                    if (tx_load) begin
                        TX_DATA  <= pbuf[rd_idx[9:0]];
                        TX_VALID <= 1'b1;
                        TX_LAST  <= (rd_idx == pkt_len - 1'b1);
                        rd_idx   <= rd_idx + 1'b1;
                    end else if (send_done) begin
                        TX_VALID <= 1'b0;
                        TX_LAST  <= 1'b0;
                        state    <= ST_COLLECT;
                    end
                end
                default: begin
                    state <= ST_COLLECT;
                end
            endcase
        end
    end

    // ==========================================================
    // Register writes
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            d1_en    <= 1'b0;
            d2_en    <= 1'b0;
            mode     <= `SDP_MODE_PASS;
            d1_val   <= RST_DELIM[7:0];
            d2_val   <= RST_DELIM[15:8];
            len_thr  <= `SDP_RST_PACK_LEN;
            idle_thr <= `SDP_RST_IDLE_MS;
        end else if (WE) begin
            case (ADDR)
                `SDP_REG_CTRL: begin
                    d1_en <= WDATA[`SDP_CTRL_D1_EN];
                    d2_en <= WDATA[`SDP_CTRL_D2_EN];
                    mode  <= WDATA[`SDP_CTRL_MODE_HI:`SDP_CTRL_MODE_LO];
                end
                `SDP_REG_DELIM: begin
                    d1_val <= WDATA[7:0];
                    d2_val <= WDATA[15:8];
                end
                `SDP_REG_PACK_LEN: begin
                    // Values above the buffer size saturate, so full still wins
                    if (WDATA > {21'h0, `SDP_LEN_MAX}) begin
                        len_thr <= `SDP_LEN_MAX;
                    end else begin
                        len_thr <= WDATA[`SDP_CNT_W-1:0];
                    end
                end
                `SDP_REG_IDLE_MS: begin
                    idle_thr <= WDATA[15:0];
                end
                default: begin
                    len_thr <= len_thr;
                end
            endcase
        end
    end

    // ==========================================================
    // Register reads, data in the cycle after the strobe
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 32'h0000_0000;
        end else if (RE) begin
            case (ADDR)
                `SDP_REG_CTRL:     RDATA <= {26'h0, mode, 2'h0, d2_en, d1_en};
                `SDP_REG_DELIM:    RDATA <= {16'h0000, d2_val, d1_val};
                `SDP_REG_PACK_LEN: RDATA <= {21'h0, len_thr};
                `SDP_REG_IDLE_MS:  RDATA <= {16'h0000, idle_thr};
                `SDP_REG_STATUS:   RDATA <= {15'h0, state, 5'h0, count};
                `SDP_REG_PKT_CNT:  RDATA <= pkt_cnt;
                default:           RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

endmodule

// ### sdp_packer_assertions.sv
`timescale 1ns/1ps
`include "sdp_map.vh"

// ==========================================================
// Port checks
module sdp_packer_assertions #(
    parameter MS_CYCLES = 4
) (
    input wire                   CLK,
    input wire                   RESETN,
    input wire [`SDP_ADDR_W-1:0] ADDR,
    input wire [31:0]            WDATA,
    input wire                   WE,
    input wire                   RE,
    input wire [31:0]            RDATA,
    input wire [7:0]             RX_DATA,
    input wire                   RX_VALID,
    input wire                   RX_READY,
    input wire [7:0]             TX_DATA,
    input wire                   TX_VALID,
    input wire                   TX_LAST,
    input wire                   TX_READY
);
    logic [15:0] n_in;
    logic [15:0] n_out;
    logic [10:0] n_pkt;
    logic [10:0] plen;

    // Shadow of the threshold; only valid while it is not changed mid-packet
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            n_in <= 16'h0000;
            n_out <= 16'h0000;
            n_pkt <= 11'h000;
            plen <= 11'h000;
        end else begin
            n_in <= n_in + {15'h0000, RX_VALID && RX_READY};
            n_out <= n_out + {15'h0000, TX_VALID && TX_READY};
            if (TX_VALID && TX_READY) begin
                n_pkt <= TX_LAST ? 11'h000 : n_pkt + 11'h001;
            end
            if (WE && ADDR == `SDP_REG_PACK_LEN) begin
                plen <= (WDATA > 32'h0000_0400) ? 11'h400 : WDATA[10:0];
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_len_cap: assert property (TX_VALID && plen != 11'h000 |-> n_pkt < plen)
        else $error("packet longer than threshold");
    a_full_cap: assert property (TX_VALID |-> n_pkt < 11'h400)
        else $error("packet longer than buffer");
    a_bytes_conserved: assert property (TX_VALID |-> n_out < n_in)
        else $error("more bytes out than in");
    a_last_gap: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID)
        else $error("no gap after last byte");
    a_tx_hold: assert property (TX_VALID && !TX_READY |=>
        TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("output changed while stalled");
    a_rdata_idle: assert property (!$past(RE) |-> RDATA == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (RE && ADDR > `SDP_REG_PKT_CNT |=> RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reset_idle: assert property ($rose(RESETN) |-> !TX_VALID && RX_READY)
        else $error("not idle after reset");
endmodule

bind sdp_packer sdp_packer_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .CLK, .RESETN, .ADDR, .WDATA, .WE, .RE, .RDATA, .RX_DATA, .RX_VALID,
    .RX_READY, .TX_DATA, .TX_VALID, .TX_LAST, .TX_READY
);

// ### sdp_packer_tb_top.sv
`timescale 1ns/1ps
`include "sdp_map.vh"

// ==========================================================
// Bench
module sdp_packer_tb_top;
    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
        $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end

    logic        CLK, RESETN, WE, RE, TX_READY, slow, stall;
    logic [7:0]  ADDR, RX_DATA, TX_DATA;
    logic [31:0] WDATA, RDATA;
    logic        RX_VALID, RX_READY, TX_VALID, TX_LAST;
    logic [7:0]  stream [0:1029];
    logic [7:0]  rxb[$];
    int          plens[$];
    int          cur = 0, cyc = 0, npk, n_tests, n_mismatch;
    int          la[4] = '{3, 4, 5, 2};
    int          ta[4] = '{3, 4, 5, 3};

    sdp_packer #(.MS_CYCLES(4)) uut (
        .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WE(WE), .RE(RE),
        .RDATA(RDATA), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY)
    );
    sdp_serial_src u_src (
        .clk(CLK), .resetn(RESETN), .slow(slow), .ready(RX_READY),
        .data(RX_DATA), .valid(RX_VALID)
    );

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // Stalling sink; collects bytes and packet lengths
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        TX_READY <= !stall || cyc[1];
        if (RESETN && TX_VALID && TX_READY) begin
            rxb.push_back(TX_DATA);
            cur++;
            if (TX_LAST) begin
                plens.push_back(cur);
                cur = 0;
            end
        end
    end

    task final_report;
        $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WE <= 1'b1;
        @(posedge CLK);
        WE <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        ADDR <= a;
        RE <= 1'b1;
        @(posedge CLK);
        RE <= 1'b0;
        #1;
        `CHK(RDATA, e)
    endtask

    task send(input int n);
        for (int i = 0; i < n; i++) u_src.q.push_back(stream[i]);
    endtask

    task pkt(input int len, input int off);
        int k;
        int got;
        logic [7:0] b;
        k = 0;
        while (plens.size() == 0 && k < 5000) begin
            @(posedge CLK);
            k++;
        end
        if (plens.size() == 0) begin
            n_mismatch++;
            final_report();
        end else begin
            got = plens.pop_front();
            npk++;
            `CHK(got, len)
            for (int i = 0; i < got; i++) begin
                b = rxb.pop_front();
                `CHK(b, stream[off + i])
            end
        end
    endtask

    // Idle release of 1 ms empties whatever is left behind
    task flush(input int off, input int len);
        wr(`SDP_REG_IDLE_MS, 32'h0000_0001);
        pkt(len, off);
        wr(`SDP_REG_IDLE_MS, 32'h0000_0000);
    endtask

    initial begin
        {WE, RE, slow, stall, npk, n_tests, n_mismatch} = '0;
        {ADDR, WDATA} = '0;
        RESETN = 1'b0;
        for (int i = 0; i < 1030; i++) stream[i] = 8'h20 + i[7:0];
        stream[2] = 8'h0D;
        stream[6] = 8'h0D;
        stream[7] = 8'h0A;
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0000_0000);
        wr(`SDP_REG_PKT_CNT, 32'h0000_0005);
        rd(`SDP_REG_PKT_CNT, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        wr(`SDP_REG_PACK_LEN, 32'h0000_07D0);
        rd(`SDP_REG_PACK_LEN, 32'h0000_0400);
        wr(`SDP_REG_CTRL, 32'h0000_0030);
        wr(`SDP_REG_PACK_LEN, 32'h0000_0004);
        send(10);
        pkt(4, 0);
        pkt(4, 4);
        repeat (60) @(posedge CLK);
        `CHK(plens.size(), 0)
        rd(`SDP_REG_STATUS, 32'h0000_0002);
        flush(8, 2);
        wr(`SDP_REG_PACK_LEN, 32'h0000_0000);
        stall <= 1'b1;
        send(1030);
        pkt(1024, 0);
        flush(1024, 6);
        stall <= 1'b0;
        wr(`SDP_REG_DELIM, 32'h0000_0A0D);
        for (int m = 0; m < 4; m++) begin
            wr(`SDP_REG_CTRL, {26'h0, m[1:0], 4'h1});
            send(6);
            pkt(la[m], 0);
            flush(ta[m], 6 - ta[m]);
        end
        slow <= 1'b1;
        wr(`SDP_REG_CTRL, 32'h0000_0003);
        send(8);
        pkt(8, 0);
        wr(`SDP_REG_CTRL, 32'h0000_0033);
        send(8);
        pkt(6, 0);
        // Delimiter 2 alone: 0x0A is the last of the eight bytes
        wr(`SDP_REG_CTRL, 32'h0000_0002);
        send(8);
        pkt(8, 0);
        rd(`SDP_REG_PKT_CNT, 32'(npk));
        final_report();
    end
endmodule

// ### sdp_serial_src.sv
`timescale 1ns/1ps

// ==========================================================
// Serial byte source
module sdp_serial_src (
    input  wire        clk,
    input  wire        resetn,
    input  wire        slow,
    input  wire        ready,
    output logic [7:0] data,
    output logic       valid
);
    logic [7:0] q[$];
    logic       gap;

    // Idle data is inverted each cycle so stale bytes never look valid
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            valid <= 1'b0;
            data <= 8'hA5;
            gap <= 1'b0;
        end else if (valid && !ready) begin
            gap <= 1'b0;
        end else if (q.size() != 0 && !(slow && gap)) begin
            valid <= 1'b1;
            data <= q.pop_front();
            gap <= 1'b1;
        end else begin
            valid <= 1'b0;
            data <= ~data;
            gap <= 1'b0;
        end
    end
endmodule
